// [design/tx_async_gearbox_66b.sv]
module tx_async_gearbox_66b (
	// Clock, reset and enable
	input  wire logic                                        i_clock,
	input  wire logic                                        i_rst,
	input  wire logic                                        i_ce,
	// Static settings
	input  wire logic                                        i_tx_gearbox_enable,
	input  wire logic [tx_gearbox_pkg::MODE_W-1:0]           i_gearbox_mode,
	input  wire logic                                        i_data_width8,
	input  wire logic [tx_gearbox_pkg::SAMPLE_SEL_W-1:0]     i_sample_period,
	// Supplier side
	input  wire logic                                        i_in_valid,
	input  wire logic [5:0]                                  i_tx_header_in,
	input  wire logic                                        i_header_cycle_indicator,
	input  wire logic [tx_gearbox_pkg::PAYLOAD_W-1:0]        i_tx_payload_in,
	// Line side
	input  wire logic                                        i_pma_tick,
	output logic      [tx_gearbox_pkg::WORD_W-1:0]           o_tx_data_out,
	output logic                                             o_tx_data_valid,
	output logic      [1:0]                                  o_tx_fifo_status,
	// Latency clock pin
	input  wire logic                                        i_latency_meas_clock,
	// Configuration access port
	input  wire logic                                        i_cfg_en,
	input  wire logic                                        i_cfg_we,
	input  wire logic [tx_gearbox_pkg::CFG_ADDR_W-1:0]       i_cfg_addr,
	output logic      [tx_gearbox_pkg::LATENCY_W-1:0]        o_cfg_rdata,
	output logic                                             o_cfg_rdy
);

	typedef struct packed {
		logic [tx_gearbox_pkg::WORD_W-1:0]    dout;
		logic                                 dvalid;
		logic [1:0]                           status;
		logic                                 caui_phase;
		logic                                 lat_meta;
		logic                                 lat_sync;
		logic                                 lat_prev;
		logic [tx_gearbox_pkg::LAT_CNT_W-1:0] lat_cnt;
		logic [tx_gearbox_pkg::LAT_SUM_W-1:0] lat_sum;
		logic [tx_gearbox_pkg::LATENCY_W-1:0] latency;
		logic [tx_gearbox_pkg::LATENCY_W-1:0] rdata;
		logic                                 rdy;
	} gbx_state_t;

	gbx_state_t gbx_reg;
	gbx_state_t gbx_next;

	// Mode decode.
	logic active;
	logic caui;
	assign active = i_tx_gearbox_enable && i_gearbox_mode[tx_gearbox_pkg::MODE_ASYNC_BIT]
		&& i_gearbox_mode[tx_gearbox_pkg::MODE_66B_BIT];
	assign caui = i_gearbox_mode[tx_gearbox_pkg::MODE_CAUI_BIT] && i_data_width8;

	// Lane controls.
	logic                                 push;
	logic                                 pull;
	logic [tx_gearbox_pkg::NBITS_W-1:0]   push_bits_a;
	logic [tx_gearbox_pkg::NBITS_W-1:0]   pull_bits;
	logic [tx_gearbox_pkg::BLOCK_W-1:0]   push_data_a;
	logic [tx_gearbox_pkg::BLOCK_W-1:0]   push_data_b;
	logic [tx_gearbox_pkg::WORD_W-1:0]    head_a;
	logic [tx_gearbox_pkg::WORD_W-1:0]    head_b;
	logic [tx_gearbox_pkg::FILL_W-1:0]    fill_a;
	logic                                 over_a;
	logic                                 over_b;
	logic                                 under_a;
	logic                                 under_b;
	logic                                 hdr_cycle;

	// Every strobe is taken; no pause slots exist on the supplier side.
	assign push = active && i_in_valid;
	assign pull = active && i_pma_tick;
	assign pull_bits = caui ? tx_gearbox_pkg::PULL_HALF : tx_gearbox_pkg::PULL_FULL;

	// Header cycle: indicator low in four-byte mode, internal alternation in dual-stream.
	always_comb begin
		hdr_cycle   = 1'b0;
		push_bits_a = tx_gearbox_pkg::PUSH_WORD;
		push_data_a = '0;
		push_data_b = '0;
		if (caui) begin
			hdr_cycle   = !gbx_reg.caui_phase;
			push_bits_a = hdr_cycle ? tx_gearbox_pkg::PUSH_HDRW : tx_gearbox_pkg::PUSH_WORD;
			push_data_a = hdr_cycle ? {32'h0000_0000, i_tx_payload_in[31:0], i_tx_header_in[1:0]}
				: {34'h0_0000_0000, i_tx_payload_in[31:0]};
			push_data_b = hdr_cycle ? {32'h0000_0000, i_tx_payload_in[63:32], i_tx_header_in[4:3]}
				: {34'h0_0000_0000, i_tx_payload_in[63:32]};
		end else if (i_data_width8) begin
			push_bits_a = tx_gearbox_pkg::PUSH_BLOCK;
			push_data_a = {i_tx_payload_in, i_tx_header_in[1:0]};
		end else begin
			hdr_cycle   = !i_header_cycle_indicator;
			push_bits_a = hdr_cycle ? tx_gearbox_pkg::PUSH_HDRW : tx_gearbox_pkg::PUSH_WORD;
			push_data_a = hdr_cycle ? {32'h0000_0000, i_tx_payload_in[31:0], i_tx_header_in[1:0]}
				: {34'h0_0000_0000, i_tx_payload_in[31:0]};
		end
	end

	// Stream A carries normal traffic; stream B is used only in dual-stream mode.
	gearbox_lane lane_a (
		.i_clock     (i_clock),
		.i_rst       (i_rst),
		.i_ce        (i_ce),
		.i_clear     (!active),
		.i_push      (push),
		.i_push_bits (push_bits_a),
		.i_push_data (push_data_a),
		.i_pull      (pull),
		.i_pull_bits (pull_bits),
		.o_head      (head_a),
		.o_fill      (fill_a),
		.o_over      (over_a),
		.o_under     (under_a)
	);

	gearbox_lane lane_b (
		.i_clock     (i_clock),
		.i_rst       (i_rst),
		.i_ce        (i_ce),
		.i_clear     (!(active && caui)),
		.i_push      (push && caui),
		.i_push_bits (push_bits_a),
		.i_push_data (push_data_b),
		.i_pull      (pull && caui),
		.i_pull_bits (pull_bits),
		.o_head      (head_b),
		.o_fill      (),
		.o_over      (over_b),
		.o_under     (under_b)
	);

	// Next state: output word, sticky status, latency averaging, config reads.
	always_comb begin
		logic                                 tick;
		logic [tx_gearbox_pkg::LAT_CNT_W-1:0] last;
		logic [tx_gearbox_pkg::LAT_SUM_W-1:0] sum;
		logic [4:0]                           sh;
		gbx_next = gbx_reg;
		tick     = 1'b0;
		last     = '0;
		sum      = '0;
		sh       = '0;

		// A word leaves on every parallel clock tick while the gearbox is active; underrun sends zeros.
		gbx_next.dvalid = pull;
		if (pull) begin
			if (caui) begin
				for (int i = 0; i < tx_gearbox_pkg::HALF_W; i++) begin
					gbx_next.dout[2*i]   = under_b ? 1'b0 : head_a[i];
					gbx_next.dout[2*i+1] = under_b ? 1'b0 : head_b[i];
				end
				if (under_a) begin
					gbx_next.dout = '0;
				end
			end else begin
				gbx_next.dout = under_a ? '0 : head_a;
			end
		end
		if (push && caui) begin
			gbx_next.caui_phase = !gbx_reg.caui_phase;
		end
		if (!active) begin
			gbx_next.caui_phase = 1'b0;
		end

		// Flags set and only reset clears them.
		if (over_a || over_b) begin
			gbx_next.status[tx_gearbox_pkg::STAT_OVER_BIT] = 1'b1;
		end
		if (under_a || under_b) begin
			gbx_next.status[tx_gearbox_pkg::STAT_UNDER_BIT] = 1'b1;
		end

		// Latency clock pin: two flops, then edge detect on the second.
		gbx_next.lat_meta = i_latency_meas_clock;
		gbx_next.lat_sync = gbx_reg.lat_meta;
		gbx_next.lat_prev = gbx_reg.lat_sync;
		tick = gbx_reg.lat_sync && !gbx_reg.lat_prev;

		// Mean fill in bits times eight equals eighths of a UI.
		last = tx_gearbox_pkg::LAT_CNT_W'(
			(1 << (tx_gearbox_pkg::SAMPLE_BASE_L + i_sample_period)) - 1);
		if (active && !caui) begin
			if (tick) begin
				sum = gbx_reg.lat_sum + {15'h0000, fill_a};
				if (gbx_reg.lat_cnt == last) begin
					sh = 5'(tx_gearbox_pkg::SAMPLE_BASE_L - tx_gearbox_pkg::UI_FRAC_L)
						+ {2'b00, i_sample_period};
					gbx_next.latency = tx_gearbox_pkg::LATENCY_W'(sum >> sh);
					gbx_next.lat_sum = '0;
					gbx_next.lat_cnt = '0;
				end else begin
					gbx_next.lat_sum = sum;
					gbx_next.lat_cnt = gbx_reg.lat_cnt + 1'b1;
				end
			end
		end else begin
			gbx_next.lat_sum = '0;
			gbx_next.lat_cnt = '0;
		end

		// Config port: one-cycle ready; writes are acknowledged and ignored.
		gbx_next.rdy = i_cfg_en;
		if (i_cfg_en) begin
			gbx_next.rdata = '0;
			if (!i_cfg_we && i_cfg_addr == tx_gearbox_pkg::GEARBOX_FIFO_LATENCY_ADDR) begin
				gbx_next.rdata = gbx_reg.latency;
			end
		end
	end

	// Clock enable low freezes all state.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			gbx_reg <= '0;
		end else if (i_ce) begin
			gbx_reg <= gbx_next;
		end
	end

	assign o_tx_data_out    = gbx_reg.dout;
	assign o_tx_data_valid  = gbx_reg.dvalid;
	assign o_tx_fifo_status = gbx_reg.status;
	assign o_cfg_rdata      = gbx_reg.rdata;
	assign o_cfg_rdy        = gbx_reg.rdy;

endmodule

// [design/tx_gearbox_pkg.sv]
package tx_gearbox_pkg;

	// Mode setting field positions.
	localparam int MODE_W         = 5;
	localparam int MODE_ASYNC_BIT = 4;
	localparam int MODE_CAUI_BIT  = 2;
	localparam int MODE_66B_BIT   = 0;

	// Status bit positions.
	localparam int STAT_UNDER_BIT = 0;
	localparam int STAT_OVER_BIT  = 1;

	// Stream widths in bits.
	localparam int HDR_W     = 2;
	localparam int WORD_W    = 32;
	localparam int PAYLOAD_W = 64;
	localparam int BLOCK_W   = HDR_W + PAYLOAD_W;
	localparam int HALF_W    = WORD_W / 2;

	// Bit buffer of one lane; one block plus slack.
	localparam int LANE_DEPTH = 128;
	localparam int FILL_W     = 8;
	localparam int NBITS_W    = 7;

	localparam logic [NBITS_W-1:0] PUSH_BLOCK = 7'h42;
	localparam logic [NBITS_W-1:0] PUSH_HDRW  = 7'h22;
	localparam logic [NBITS_W-1:0] PUSH_WORD  = 7'h20;
	localparam logic [NBITS_W-1:0] PULL_FULL  = 7'h20;
	localparam logic [NBITS_W-1:0] PULL_HALF  = 7'h10;

	// Latency measurement.
	localparam int SAMPLE_SEL_W  = 3;
	localparam int SAMPLE_BASE_L = 8;
	localparam int UI_FRAC_L     = 3;
	localparam int LAT_CNT_W     = 15;
	localparam int LAT_SUM_W     = 23;
	localparam int LATENCY_W     = 16;

	// Configuration access port.
	localparam int CFG_ADDR_W = 10;
	localparam logic [CFG_ADDR_W-1:0] GEARBOX_FIFO_LATENCY_ADDR = 10'h163;

endpackage

// [design/gearbox_lane.sv]
// One bit-serial lane: words are appended at the fill level, oldest bit at bit 0.
module gearbox_lane (
	// Clock and reset
	input  wire logic                                  i_clock,
	input  wire logic                                  i_rst,
	input  wire logic                                  i_ce,
	input  wire logic                                  i_clear,
	// Write side
	input  wire logic                                  i_push,
	input  wire logic [tx_gearbox_pkg::NBITS_W-1:0]    i_push_bits,
	input  wire logic [tx_gearbox_pkg::BLOCK_W-1:0]    i_push_data,
	// Read side
	input  wire logic                                  i_pull,
	input  wire logic [tx_gearbox_pkg::NBITS_W-1:0]    i_pull_bits,
	output logic      [tx_gearbox_pkg::WORD_W-1:0]     o_head,
	output logic      [tx_gearbox_pkg::FILL_W-1:0]     o_fill,
	output logic                                       o_over,
	output logic                                       o_under
);

	typedef struct packed {
		logic [tx_gearbox_pkg::LANE_DEPTH-1:0] bits;
		logic [tx_gearbox_pkg::FILL_W-1:0]     fill;
	} lane_state_t;

	lane_state_t lane_reg;
	lane_state_t lane_next;

	// Read before write, so a pull frees room for the push in the same cycle.
	always_comb begin
		logic [tx_gearbox_pkg::FILL_W:0]         room;
		logic [tx_gearbox_pkg::LANE_DEPTH-1:0]   ext;
		lane_next = lane_reg;
		o_over    = 1'b0;
		o_under   = 1'b0;
		room      = '0;
		ext       = {{(tx_gearbox_pkg::LANE_DEPTH - tx_gearbox_pkg::BLOCK_W){1'b0}}, i_push_data};
		if (i_pull) begin
			if (lane_reg.fill >= {1'b0, i_pull_bits}) begin
				lane_next.bits = lane_reg.bits >> i_pull_bits;
				lane_next.fill = lane_reg.fill - {1'b0, i_pull_bits};
			end else begin
				o_under = 1'b1;
			end
		end
		if (i_push) begin
			room = {1'b0, lane_next.fill} + {2'b00, i_push_bits};
			if (room > 9'(tx_gearbox_pkg::LANE_DEPTH)) begin
				o_over = 1'b1;
			end else begin
				lane_next.bits = lane_next.bits | (ext << lane_next.fill);
				lane_next.fill = room[tx_gearbox_pkg::FILL_W-1:0];
			end
		end
		if (i_clear) begin
			lane_next = '0;
		end
	end

	// Clock enable freezes the buffer.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			lane_reg <= '0;
		end else if (i_ce) begin
			lane_reg <= lane_next;
		end
	end

	assign o_head = lane_reg.bits[tx_gearbox_pkg::WORD_W-1:0];
	assign o_fill = lane_reg.fill;

endmodule

// [sim/tx_async_gearbox_66b_assertions.sv]
module tx_gearbox_checker (
	// Clock, reset and settings
	input  wire logic                                  i_clock,
	input  wire logic                                  i_rst,
	input  wire logic                                  i_ce,
	input  wire logic                                  i_tx_gearbox_enable,
	input  wire logic [tx_gearbox_pkg::MODE_W-1:0]     i_gearbox_mode,
	// Requests
	input  wire logic                                  i_in_valid,
	input  wire logic                                  i_pma_tick,
	input  wire logic                                  i_cfg_en,
	input  wire logic [tx_gearbox_pkg::CFG_ADDR_W-1:0] i_cfg_addr,
	// Answers
	input  wire logic                                  o_tx_data_valid,
	input  wire logic [1:0]                            o_tx_fifo_status,
	input  wire logic [tx_gearbox_pkg::LATENCY_W-1:0]  o_cfg_rdata,
	input  wire logic                                  o_cfg_rdy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic act;

	// The gearbox only runs with enable, asynchronous select and 66B select all high.
	// Clock enable is kept apart: a frozen cycle holds every output as it was.
	assign act = i_tx_gearbox_enable & i_gearbox_mode[4] & i_gearbox_mode[0];

	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);

	a_tick_gives_word: assert property (i_ce && i_pma_tick && act |=> o_tx_data_valid)
		else $error("tick without output word");
	a_word_has_tick: assert property (o_tx_data_valid && $past(i_ce)
		|-> $past(i_pma_tick && act))
		else $error("output word without tick");
	a_idle_no_word: assert property (i_ce && !act |=> !o_tx_data_valid)
		else $error("word while gearbox disabled");
	a_over_sticky: assert property (o_tx_fifo_status[1] |=> o_tx_fifo_status[1])
		else $error("overflow flag dropped");
	a_under_sticky: assert property (o_tx_fifo_status[0] |=> o_tx_fifo_status[0])
		else $error("underflow flag dropped");
	a_over_cause: assert property ($rose(o_tx_fifo_status[1])
		|-> $past(i_in_valid) || $past(i_in_valid, 2))
		else $error("overflow without a pushed word");
	a_under_cause: assert property ($rose(o_tx_fifo_status[0])
		|-> $past(i_pma_tick) || $past(i_pma_tick, 2))
		else $error("underflow without a tick");
	a_cfg_answer: assert property (i_ce && i_cfg_en |=> o_cfg_rdy)
		else $error("config access not acknowledged");
	a_cfg_unmapped: assert property (i_ce && i_cfg_en && i_cfg_addr != 10'h163
		|=> o_cfg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!(i_ce && i_cfg_en) |=> $stable(o_cfg_rdata))
		else $error("read data moved without access");
endmodule

bind tx_async_gearbox_66b tx_gearbox_checker chk_u (.i_clock, .i_rst, .i_ce,
	.i_tx_gearbox_enable, .i_gearbox_mode, .i_in_valid, .i_pma_tick, .i_cfg_en,
	.i_cfg_addr, .o_tx_data_valid, .o_tx_fifo_status, .o_cfg_rdata, .o_cfg_rdy);

// [sim/fabric_supplier.sv]
module fabric_supplier (
	// Clock
	input  wire logic        i_clock,
	// Stream toward the gearbox
	output logic             o_in_valid,
	output logic [5:0]       o_tx_header_in,
	output logic             o_header_cycle_indicator,
	output logic [63:0]      o_tx_payload_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// Present one word for one interface cycle; calls in a row stream with no pause.
	task automatic send(input logic [5:0] hdr, input logic [63:0] pay, input logic seq);
		o_in_valid = 1'h1;
		o_tx_header_in = hdr;
		o_header_cycle_indicator = seq;
		o_tx_payload_in = pay;
		@(negedge i_clock);
	endtask

	// Released header and payload lines show inverted stale values so old data cannot match by luck.
	task automatic stop();
		o_in_valid = 1'h0;
		o_tx_header_in = ~o_tx_header_in;
		o_tx_payload_in = ~o_tx_payload_in;
	endtask

	// Quiet stream at time zero.
	initial begin
		o_in_valid = 1'h0;
		o_tx_header_in = 6'h00;
		o_header_cycle_indicator = 1'h0;
		o_tx_payload_in = 64'h0;
	end
endmodule

// [sim/tx_async_gearbox_66b_tb.sv]
module tx_async_gearbox_66b_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'h0, i_rst = 1'h1, en = 1'h0, w8 = 1'h0, tick = 1'h0, cen = 1'h0;
	logic lclk = 1'h0, vld, seq, rdy, iv;
	logic [4:0] mode = 5'h00;
	logic ce = 1'h1;
	logic [2:0] sp = 3'h0;
	logic [9:0] caddr = 10'h000;
	logic [5:0] hdr;
	logic [63:0] pay;
	logic [31:0] dout, got;
	logic [1:0] stat;
	logic [15:0] rdata;
	logic [31:0] expq[$];
	int n_fail = 0, n_tests = 0;
	integer seed = 71;

	tx_async_gearbox_66b dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_ce(ce),
		.i_tx_gearbox_enable(en), .i_gearbox_mode(mode), .i_data_width8(w8),
		.i_sample_period(sp), .i_in_valid(iv), .i_tx_header_in(hdr),
		.i_header_cycle_indicator(seq), .i_tx_payload_in(pay), .i_pma_tick(tick),
		.o_tx_data_out(dout), .o_tx_data_valid(vld), .o_tx_fifo_status(stat),
		.i_latency_meas_clock(lclk), .i_cfg_en(cen), .i_cfg_we(1'h0), .i_cfg_addr(caddr),
		.o_cfg_rdata(rdata), .o_cfg_rdy(rdy));
	fabric_supplier sup_u (.i_clock(i_clock), .o_in_valid(iv), .o_tx_header_in(hdr),
		.o_header_cycle_indicator(seq), .o_tx_payload_in(pay));

	// Free-running 40 MHz clock; strobes on it stand for the divided user clocks.
	initial forever #12.5 i_clock = ~i_clock;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Settings change only under reset, held for two cycles.
	task automatic restart(input logic e, input logic [4:0] m, input logic w);
		i_rst = 1'h1;
		en = e;
		mode = m;
		w8 = w;
		repeat (2) @(negedge i_clock);
		i_rst = 1'h0;
	endtask

	// One parallel-clock request; the spare cycle keeps strobe edges apart.
	task automatic pull(input logic want, input logic [31:0] e);
		tick = 1'h1;
		if (want) expq.push_back(e);
		@(negedge i_clock);
		tick = 1'h0;
		@(negedge i_clock);
	endtask

	task automatic cread(input logic [9:0] a, input logic [15:0] e);
		cen = 1'h1;
		caddr = a;
		expq.push_back({16'h0000, e});
		@(negedge i_clock);
		cen = 1'h0;
		@(negedge i_clock);
	endtask

	// Latency clock pin, off the main clock grid; each level spans at least one edge.
	task automatic lat_edges();
		repeat (300) begin
			#40 lclk = 1'h1;
			#45 lclk = 1'h0;
		end
		@(negedge i_clock);
	endtask

	// Every answer is paired with the oldest note; an unnoted answer always mismatches.
	always @(negedge i_clock) begin
		if (!i_rst && (vld === 1'h1 || rdy === 1'h1)) begin
			got = vld ? dout : {16'h0000, rdata};
			if (expq.size() == 0) chk(got, ~got);
			else chk(got, expq.pop_front());
		end
	end

	// Cut a hang short.
	initial begin
		repeat (20000) @(posedge i_clock);
		n_fail++;
		final_report();
	end

	initial begin
		logic [65:0] b;
		logic [65:0] a, c;
		logic [31:0] e;
		restart(1'h1, 5'h11, 1'h1);
		chk({30'h0, stat}, 32'h0);
		@(negedge i_clock);
		// Narrow pass also sets the unused mode bits; wide pass overflows with a second block.
		for (int w = 0; w < 2; w++) begin
			restart(1'h1, w ? 5'h11 : 5'h1B, w[0]);
			pay = {$random(seed), $random(seed)};
			b = {pay, 2'($random(seed))};
			if (w) sup_u.send({4'h0, b[1:0]}, pay, 1'h0);
			else begin
				sup_u.send({4'h0, b[1:0]}, pay, 1'h0);
				sup_u.send(~{4'h0, b[1:0]}, {pay[31:0], pay[63:32]}, 1'h1);
			end
			if (w) sup_u.send(6'h3F, ~pay, 1'h0);
			sup_u.stop();
			pull(1'h1, b[31:0]);
			pull(1'h1, b[63:32]);
			pull(1'h1, 32'h0);
			chk({30'h0, stat}, {30'h0, w[0], 1'h1});
			$display("test normal width %0d done", w);
		end
		// Each disabling setting must leave the line side silent.
		for (int k = 0; k < 3; k++) begin
			restart(k != 0, k == 1 ? 5'h01 : (k == 2 ? 5'h10 : 5'h11), 1'h1);
			sup_u.send(6'h01, pay, 1'h0);
			sup_u.stop();
			pull(1'h0, 32'h0);
		end
		chk({30'h0, stat}, 32'h0);
		$display("test disabled modes done");
		restart(1'h1, 5'h15, 1'h1);
		pay = {$random(seed), $random(seed)};
		e = $random(seed);
		// Second word per stream carries no header; its inverted header must be ignored.
		a = {pay, e[1:0]};
		c = {pay[31:0], pay[63:32], e[4:3]};
		sup_u.send(e[5:0], pay, 1'h0);
		sup_u.send(~e[5:0], {pay[31:0], pay[63:32]}, 1'h0);
		sup_u.stop();
		// A frozen clock enable must neither answer a tick nor drain the lanes.
		ce = 1'h0;
		pull(1'h0, 32'h0);
		ce = 1'h1;
		for (int h = 0; h < 4; h++) begin
			for (int i = 0; i < 16; i++) {e[2*i+1], e[2*i]} = {c[16*h+i], a[16*h+i]};
			pull(1'h1, e);
		end
		// Dual-stream mode never measures, so the latency keeps its reset value.
		lat_edges();
		cread(10'h163, 16'h0000);
		$display("test dual stream done");
		// A block held still makes the mean fill 66 bits, reported in eighths.
		// The longer period must still read zero before its first refresh.
		for (int s = 0; s < 2; s++) begin
			sp = 3'(s);
			restart(1'h1, 5'h11, 1'h1);
			sup_u.send(6'h02, pay, 1'h0);
			sup_u.stop();
			for (int r = 0; r <= s; r++) begin
				lat_edges();
				cread(10'h163, (r == s) ? 16'h0210 : 16'h0000);
			end
		end
		cread(10'h100, 16'h0000);
		$display("test latency done");
		repeat (3) @(negedge i_clock);
		chk(32'(expq.size()), 32'h0);
		final_report();
	end
endmodule
